// >>> hdl/ifeb_bank.sv
// interrupt flag and enable bank with request forwarding
//
// Notes on behaviour
// - flag reads 1 after its source raised
// - enable bit passes or blocks the request
// - unimplemented bits read 0, ignore writes
// - implemented bits clear at reset
// - software reads and writes every implemented bit
// - flags group3: calendar, pin events, i2c b
// - flags group4: checksum, serial errors only
// - enables group0 upper: conversion through timer b
// - enables group0 lower: compares, captures, timer, pin0
// - enables group1 upper: serial b through compare c
// - enables group1 lower: pin1, change, comparator, i2c
// - enables group2: parallel port, compare, captures, spi
// - enables group3 mirrors flags group3 layout
// - priority zero disables, seven highest
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/10ps

module ifeb_bank
    import ifeb_pkg::*;
#(
    parameter int ADDR_W = IFEB_AW
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // register port
    input wire ifeb_bus_s bus_in,
    output ifeb_word_t rdata_out,
    // peripheral events for groups 3 and 4 (one cycle each)
    input wire ifeb_word_t evt_grp3_in,
    input wire ifeb_word_t evt_grp4_in,
    // state held outside: flags of groups 0..2, enables of group 4
    input wire ifeb_vec_t ext_flags_in,
    input wire ifeb_word_t ext_en_grp4_in,
    input wire ifeb_prio_t prio_in,
    // toward the core
    output ifeb_vec_t core_req_out,
    output logic [IFEB_PW-1:0] core_level_out,
    // block interrupt
    output logic irq_out
);

    // the register port is fixed at four address bits
    if (ADDR_W != IFEB_AW) begin : g_bad_aw
        $error("ifeb_bank: ADDR_W must equal the package address width");
    end

    ifeb_word_t flags3_reg;
    ifeb_word_t flags4_reg;
    ifeb_word_t en0_reg;
    ifeb_word_t en1_reg;
    ifeb_word_t en2_reg;
    ifeb_word_t en3_reg;
    logic [IFEB_IRQ_BITS-1:0] stat_reg;
    logic [IFEB_IRQ_BITS-1:0] irq_en_reg;
    ifeb_word_t flags3_next;
    ifeb_word_t flags4_next;
    ifeb_word_t rdata_next;
    logic mapped;
    ifeb_vec_t flag_all;
    ifeb_vec_t en_all;
    ifeb_vec_t req_next;
    logic [IFEB_PW-1:0] level_next;
    logic [IFEB_IRQ_BITS-1:0] stat_set;

    // write strobe for one offset
    function automatic logic wr_hit(ifeb_bus_s b, ifeb_addr_t off);
        return b.wr && (b.addr == off);
    endfunction

    // sources whose priority field is not the disabled code
    function automatic ifeb_word_t prio_live(logic [IFEB_DW-1:0][IFEB_PW-1:0] p);
        ifeb_word_t v;
        v = '0;
        for (int i = 0; i < IFEB_DW; i++) begin
            v[i] = (p[i] != IFEB_PRIO_OFF);
        end
        return v;
    endfunction

    // flag next values: a write lands first, then events OR in, so an event
    // in the same cycle as a clearing write is never lost
    always_comb begin
        flags3_next = flags3_reg;
        flags4_next = flags4_reg;
        if (wr_hit(bus_in, IFEB_OFF_FLAGS3)) begin
            flags3_next = bus_in.wdata & IFEB_MASK_FLAGS3;
        end
        if (wr_hit(bus_in, IFEB_OFF_FLAGS4)) begin
            flags4_next = bus_in.wdata & IFEB_MASK_FLAGS4;
        end
        flags3_next = flags3_next | (evt_grp3_in & IFEB_MASK_FLAGS3);
        flags4_next = flags4_next | (evt_grp4_in & IFEB_MASK_FLAGS4);
    end

    // flag registers
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags3_reg <= IFEB_RST_WORD;
            flags4_reg <= IFEB_RST_WORD;
        end else begin
            flags3_reg <= flags3_next;
            flags4_reg <= flags4_next;
        end
    end

    // enable registers, unimplemented positions masked off on write
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            en0_reg <= IFEB_RST_WORD;
            en1_reg <= IFEB_RST_WORD;
            en2_reg <= IFEB_RST_WORD;
            en3_reg <= IFEB_RST_WORD;
        end else begin
            if (wr_hit(bus_in, IFEB_OFF_EN0)) begin
                en0_reg <= bus_in.wdata & IFEB_MASK_EN0;
            end
            if (wr_hit(bus_in, IFEB_OFF_EN1)) begin
                en1_reg <= bus_in.wdata & IFEB_MASK_EN1;
            end
            if (wr_hit(bus_in, IFEB_OFF_EN2)) begin
                en2_reg <= bus_in.wdata & IFEB_MASK_EN2;
            end
            if (wr_hit(bus_in, IFEB_OFF_EN3)) begin
                en3_reg <= bus_in.wdata & IFEB_MASK_EN3;
            end
        end
    end

    // gather all five groups for forwarding
    assign flag_all = {flags4_reg, flags3_reg, ext_flags_in[2], ext_flags_in[1],
                       ext_flags_in[0]};
    assign en_all = {ext_en_grp4_in, en3_reg, en2_reg, en1_reg, en0_reg};

    // forwarded requests and the highest live level among them
    always_comb begin
        level_next = IFEB_PRIO_OFF;
        for (int g = 0; g < IFEB_GROUPS; g++) begin
            req_next[g] = flag_all[g] & en_all[g] & prio_live(prio_in[g]);
            for (int i = 0; i < IFEB_DW; i++) begin
                if (req_next[g][i] && (prio_in[g][i] > level_next)) begin
                    level_next = prio_in[g][i];
                end
            end
        end
    end

    // registered request outputs keep the core side glitch free
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            core_req_out <= '0;
            core_level_out <= IFEB_PRIO_OFF;
        end else begin
            core_req_out <= req_next;
            core_level_out <= level_next;
        end
    end

    // read decode; unmapped and write-only offsets answer zero
    always_comb begin
        mapped = 1'b1;
        rdata_next = '0;
        unique case (bus_in.addr)
            IFEB_OFF_FLAGS3: rdata_next = flags3_reg;
            IFEB_OFF_FLAGS4: rdata_next = flags4_reg;
            IFEB_OFF_EN0: rdata_next = en0_reg;
            IFEB_OFF_EN1: rdata_next = en1_reg;
            IFEB_OFF_EN2: rdata_next = en2_reg;
            IFEB_OFF_EN3: rdata_next = en3_reg;
            IFEB_OFF_IRQ_STAT: rdata_next = {13'h0000, stat_reg};
            IFEB_OFF_IRQ_CLR: rdata_next = '0;
            IFEB_OFF_IRQ_EN: rdata_next = {13'h0000, irq_en_reg};
            default: mapped = 1'b0;
        endcase
    end

    // read data valid only in the cycle after the read strobe
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= '0;
        end else if (bus_in.rd) begin
            rdata_out <= rdata_next;
        end else begin
            rdata_out <= '0;
        end
    end

    // block events: any new flag in group 3 or 4, or a stray access
    assign stat_set[IFEB_IRQ_SET3] = |(evt_grp3_in & IFEB_MASK_FLAGS3 & ~flags3_reg);
    assign stat_set[IFEB_IRQ_SET4] = |(evt_grp4_in & IFEB_MASK_FLAGS4 & ~flags4_reg);
    assign stat_set[IFEB_IRQ_BADADDR] = (bus_in.wr || bus_in.rd) && !mapped;

    // sticky status, set wins over a clear in the same cycle
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stat_reg <= '0;
        end else if (wr_hit(bus_in, IFEB_OFF_IRQ_CLR)) begin
            stat_reg <= (stat_reg & ~bus_in.wdata[IFEB_IRQ_BITS-1:0]) | stat_set;
        end else begin
            stat_reg <= stat_reg | stat_set;
        end
    end

    // block interrupt enable register
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_en_reg <= '0;
        end else if (wr_hit(bus_in, IFEB_OFF_IRQ_EN)) begin
            irq_en_reg <= bus_in.wdata[IFEB_IRQ_BITS-1:0] & IFEB_IRQ_MASK;
        end
    end

    assign irq_out = |(stat_reg & irq_en_reg);

    // checks on the bank, all on the one clock
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // helper: high only in the first cycle after reset release
    logic first_reg;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    sequence s_flag3_write;
        wr_hit(bus_in, IFEB_OFF_FLAGS3) && (evt_grp3_in == '0);
    endsequence

    sequence s_flag3_read;
        bus_in.rd && (bus_in.addr == IFEB_OFF_FLAGS3);
    endsequence

    a_event_sets_flag: assert property (
        (|(evt_grp3_in & IFEB_MASK_FLAGS3)) |=>
            ((flags3_reg & $past(evt_grp3_in & IFEB_MASK_FLAGS3))
             == $past(evt_grp3_in & IFEB_MASK_FLAGS3)))
        else $error("group 3 event did not set its flag");

    a_enable_blocks_req: assert property (
        (flags3_reg[14] && !en3_reg[14]) |=> !core_req_out[3][14])
        else $error("disabled source was forwarded");

    a_unimpl_zero: assert property (
        ((flags3_reg & ~IFEB_MASK_FLAGS3) == '0) && ((en1_reg & ~IFEB_MASK_EN1) == '0)
        && ((flags4_reg & ~IFEB_MASK_FLAGS4) == '0) && ((en0_reg & ~IFEB_MASK_EN0) == '0)
        && ((en2_reg & ~IFEB_MASK_EN2) == '0) && ((en3_reg & ~IFEB_MASK_EN3) == '0))
        else $error("unimplemented bit is set");

    a_reset_clean: assert property (
        first_reg |-> (flags3_reg == '0) && (flags4_reg == '0) && (en0_reg == '0)
            && (en2_reg == '0) && (core_req_out == '0)
            && (en1_reg == '0) && (en3_reg == '0) && (stat_reg == '0))
        else $error("bank not clear after reset");

    a_write_then_read: assert property (
        s_flag3_write ##1 s_flag3_read |=>
            (rdata_out == ($past(bus_in.wdata, 2) & IFEB_MASK_FLAGS3)))
        else $error("flag write not read back");

    a_en0_layout: assert property (
        wr_hit(bus_in, IFEB_OFF_EN0) |=>
            (en0_reg[4] == 1'b0) && (en0_reg[0] == $past(bus_in.wdata[0])))
        else $error("enable group 0 layout wrong");

    a_prio_zero_off: assert property (
        (prio_in[0][3] == IFEB_PRIO_OFF) |=> !core_req_out[0][3])
        else $error("priority zero source forwarded");

    a_req_forward: assert property (
        (flags4_reg[3] && ext_en_grp4_in[3] && (prio_in[4][3] != IFEB_PRIO_OFF)) |=>
            core_req_out[4][3] && (core_level_out >= $past(prio_in[4][3])))
        else $error("live request not forwarded at its level");

    a_clear_set_wins: assert property (
        (wr_hit(bus_in, IFEB_OFF_IRQ_CLR) && (stat_set != '0)) |=>
            ((stat_reg & $past(stat_set)) == $past(stat_set)))
        else $error("status event lost under clear");

    // register layout after a clean write, one check per group of bits
    sequence s_flag4_write;
        wr_hit(bus_in, IFEB_OFF_FLAGS4) && (evt_grp4_in == '0);
    endsequence

    a_flags3_layout: assert property (
        s_flag3_write |=> (flags3_reg == ($past(bus_in.wdata) & IFEB_MASK_FLAGS3)))
        else $error("flags group 3 layout wrong");

    a_flags4_layout: assert property (
        s_flag4_write |=> (flags4_reg[3:1] == $past(bus_in.wdata[3:1]))
            && (flags4_reg[15:4] == 12'h000) && !flags4_reg[0])
        else $error("flags group 4 layout wrong");

    a_en0_upper: assert property (
        wr_hit(bus_in, IFEB_OFF_EN0) |=>
            (en0_reg[13:5] == $past(bus_in.wdata[13:5])) && (en0_reg[15:14] == 2'h0))
        else $error("enable group 0 upper layout wrong");

    a_en1_upper: assert property (
        wr_hit(bus_in, IFEB_OFF_EN1) |=> (en1_reg[15:9] == $past(bus_in.wdata[15:9])))
        else $error("enable group 1 upper layout wrong");

    a_en1_lower: assert property (
        wr_hit(bus_in, IFEB_OFF_EN1) |=>
            (en1_reg[4:0] == $past(bus_in.wdata[4:0])) && (en1_reg[8:5] == 4'h0))
        else $error("enable group 1 lower layout wrong");

    a_en2_layout: assert property (
        wr_hit(bus_in, IFEB_OFF_EN2) |=>
            (en2_reg == ($past(bus_in.wdata) & IFEB_MASK_EN2)))
        else $error("enable group 2 layout wrong");

    // enables of group 3 sit where the flags of group 3 sit
    a_en3_mirror: assert property (
        wr_hit(bus_in, IFEB_OFF_EN3) |=>
            (en3_reg == ($past(bus_in.wdata) & IFEB_MASK_FLAGS3)))
        else $error("enable group 3 does not mirror flags group 3");

    // a flag only drops when software writes its register
    a_flag3_sticky: assert property (
        !wr_hit(bus_in, IFEB_OFF_FLAGS3) |=>
            ((flags3_reg & $past(flags3_reg)) == $past(flags3_reg)))
        else $error("group 3 flag dropped without a write");

    a_flag4_sticky: assert property (
        !wr_hit(bus_in, IFEB_OFF_FLAGS4) |=>
            ((flags4_reg & $past(flags4_reg)) == $past(flags4_reg)))
        else $error("group 4 flag dropped without a write");

    a_enable_passes_req: assert property (
        (flags3_reg[14] && en3_reg[14] && (prio_in[3][14] != IFEB_PRIO_OFF)) |=>
            core_req_out[3][14])
        else $error("enabled source was not forwarded");

    // nothing reaches the core that was not flagged and enabled
    a_req_needs_all: assert property (
        1'b1 |=> ((core_req_out & ~$past(flag_all & en_all)) == '0))
        else $error("request forwarded without flag and enable");

    a_idle_level_zero: assert property (
        (req_next == '0) |=> (core_level_out == IFEB_PRIO_OFF))
        else $error("level shown with no live request");

    // read data stands one cycle, unmapped offsets answer zero
    a_read_stands_once: assert property (
        !bus_in.rd |=> (rdata_out == '0))
        else $error("read data outside its cycle");

    a_unmapped_zero: assert property (
        (bus_in.rd && !mapped) |=> (rdata_out == '0))
        else $error("unmapped offset read nonzero");

    // block status ignores writes, clears on a one, enable takes its bits
    a_stat_write_ignored: assert property (
        (wr_hit(bus_in, IFEB_OFF_IRQ_STAT) && (stat_set == '0)) |=>
            (stat_reg == $past(stat_reg)))
        else $error("status changed by a write");

    a_clear_drops_stat: assert property (
        (wr_hit(bus_in, IFEB_OFF_IRQ_CLR) && (stat_set == '0)) |=>
            ((stat_reg & $past(bus_in.wdata[IFEB_IRQ_BITS-1:0])) == '0))
        else $error("status bit survived its clear");

    a_irq_en_write: assert property (
        wr_hit(bus_in, IFEB_OFF_IRQ_EN) |=>
            (irq_en_reg == $past(bus_in.wdata[IFEB_IRQ_BITS-1:0])))
        else $error("block interrupt enable not written");

endmodule

// >>> inc/ifeb_pkg.sv
// shared constants and types for the interrupt flag and enable bank
package ifeb_pkg;

    // widths
    localparam int IFEB_DW = 16;
    localparam int IFEB_AW = 4;
    localparam int IFEB_GROUPS = 5;
    localparam int IFEB_PW = 3;

    typedef logic [IFEB_AW-1:0] ifeb_addr_t;
    typedef logic [IFEB_DW-1:0] ifeb_word_t;
    typedef logic [IFEB_GROUPS-1:0][IFEB_DW-1:0] ifeb_vec_t;
    typedef logic [IFEB_GROUPS-1:0][IFEB_DW-1:0][IFEB_PW-1:0] ifeb_prio_t;

    // register port request
    typedef struct packed {
        ifeb_addr_t addr;
        ifeb_word_t wdata;
        logic wr;
        logic rd;
    } ifeb_bus_s;

    // register offsets (word index on the plain port)
    localparam ifeb_addr_t IFEB_OFF_FLAGS3 = 4'h0;
    localparam ifeb_addr_t IFEB_OFF_FLAGS4 = 4'h1;
    localparam ifeb_addr_t IFEB_OFF_EN0 = 4'h2;
    localparam ifeb_addr_t IFEB_OFF_EN1 = 4'h3;
    localparam ifeb_addr_t IFEB_OFF_EN2 = 4'h4;
    localparam ifeb_addr_t IFEB_OFF_EN3 = 4'h5;
    localparam ifeb_addr_t IFEB_OFF_IRQ_STAT = 4'h6;
    localparam ifeb_addr_t IFEB_OFF_IRQ_CLR = 4'h7;
    localparam ifeb_addr_t IFEB_OFF_IRQ_EN = 4'h8;

    // implemented bit masks
    // calendar 14, pin events 6 5, i2c b master 2 slave 1
    localparam ifeb_word_t IFEB_MASK_FLAGS3 = 16'h4066;
    // checksum 3, serial b error 2, serial a error 1
    localparam ifeb_word_t IFEB_MASK_FLAGS4 = 16'h000E;
    // bits 13..5 and 3..0
    localparam ifeb_word_t IFEB_MASK_EN0 = 16'h3FEF;
    // bits 15..9 and 4..0
    localparam ifeb_word_t IFEB_MASK_EN1 = 16'hFE1F;
    // bits 13, 9, 7..5, 1, 0
    localparam ifeb_word_t IFEB_MASK_EN2 = 16'h22E3;
    // same layout as flags group 3
    localparam ifeb_word_t IFEB_MASK_EN3 = 16'h4066;

    // reset value of every implemented bit
    localparam ifeb_word_t IFEB_RST_WORD = 16'h0000;

    // block interrupt status bits
    localparam int IFEB_IRQ_BITS = 3;
    localparam int IFEB_IRQ_SET3 = 0;
    localparam int IFEB_IRQ_SET4 = 1;
    localparam int IFEB_IRQ_BADADDR = 2;
    localparam logic [IFEB_IRQ_BITS-1:0] IFEB_IRQ_MASK = 3'h7;
    localparam logic [IFEB_PW-1:0] IFEB_PRIO_OFF = 3'h0;

endpackage

// >>> verification/ifeb_src_model.sv
// peripheral event source model: one-cycle request pulses per source bit
`timescale 1ns/10ps

module ifeb_src_model
    import ifeb_pkg::*;
(
    // clock
    input wire logic sys_clk_in,
    // event pulses toward the bank
    output ifeb_word_t evt_grp3_out,
    output ifeb_word_t evt_grp4_out
);
    // lines rest low between events, a held level would look like a new event
    initial begin
        evt_grp3_out = '0;
        evt_grp4_out = '0;
    end

    // one cycle pulse, raised and dropped just after rising edges
    task automatic pulse(input ifeb_word_t m3, input ifeb_word_t m4);
        @(posedge sys_clk_in);
        evt_grp3_out <= m3;
        evt_grp4_out <= m4;
        @(posedge sys_clk_in);
        evt_grp3_out <= '0;
        evt_grp4_out <= '0;
    endtask
endmodule

// >>> verification/tb.sv
// self-checking bench for the interrupt flag and enable bank
`timescale 1ns/10ps
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: %s", $time, m); end end

module tb
    import ifeb_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    ifeb_bus_s bus_in = '0;
    ifeb_word_t rdata, evt3, evt4, e, d;
    ifeb_word_t ext_en4 = '0;
    ifeb_vec_t ext_flags = '0;
    ifeb_vec_t core_req, exp_req;
    ifeb_prio_t prio = '0;
    ifeb_prio_t pt;
    logic [IFEB_PW-1:0] level;
    logic irq;
    logic rd_d = 1'b0;
    ifeb_word_t q[$];
    ifeb_word_t msk [0:5];
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    integer seed = 32'h8200;

    always #25 sys_clk_in = ~sys_clk_in;

    ifeb_bank i_ifeb_bank (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .bus_in(bus_in),
        .rdata_out(rdata), .evt_grp3_in(evt3), .evt_grp4_in(evt4), .ext_flags_in(ext_flags),
        .ext_en_grp4_in(ext_en4), .prio_in(prio), .core_req_out(core_req),
        .core_level_out(level), .irq_out(irq));
    ifeb_src_model i_ifeb_src_model (.sys_clk_in(sys_clk_in), .evt_grp3_out(evt3),
        .evt_grp4_out(evt4));

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // one bus cycle per call, so strobes stay one cycle and may run back to back
    task automatic bus(input ifeb_addr_t a, input ifeb_word_t dt, input logic w, input logic r);
        @(posedge sys_clk_in);
        bus_in <= '{addr: a, wdata: dt, wr: w, rd: r};
    endtask
    task automatic wr(input ifeb_addr_t a, input ifeb_word_t dt);
        bus(a, dt, 1'b1, 1'b0);
    endtask
    task automatic rd(input ifeb_addr_t a, input ifeb_word_t ex);
        q.push_back(ex);
        bus(a, '0, 1'b0, 1'b1);
    endtask
    task automatic idle(input int n);
        repeat (n) bus('0, '0, 1'b0, 1'b0);
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge sys_clk_in) begin
        rd_d <= bus_in.rd;
        if (rd_d) begin
            e = q.pop_front();
            `CHK(rdata, e, "read data")
        end
    end

    // hang guard, the whole run needs well under two hundred cycles
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            test_done();
        end
    end

    initial begin
        msk = '{IFEB_MASK_FLAGS3, IFEB_MASK_FLAGS4, IFEB_MASK_EN0, IFEB_MASK_EN1,
            IFEB_MASK_EN2, IFEB_MASK_EN3};
        repeat (8) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 9; i++) rd(ifeb_addr_t'(i), IFEB_RST_WORD);
        // unmapped access reads zero and is flagged; status ignores writes
        rd(4'h9, 16'h0000);
        idle(1);
        wr(IFEB_OFF_IRQ_STAT, 16'hFFFF);
        rd(IFEB_OFF_IRQ_STAT, 16'h0004);
        // ones, zeros and random data through every flag and enable word
        for (int i = 0; i < 6; i++) begin
            wr(ifeb_addr_t'(i), 16'hFFFF);
            rd(ifeb_addr_t'(i), msk[i]);
            wr(ifeb_addr_t'(i), 16'h0000);
            rd(ifeb_addr_t'(i), 16'h0000);
            d = ifeb_word_t'($random(seed));
            wr(ifeb_addr_t'(i), d);
            rd(ifeb_addr_t'(i), d & msk[i]);
            wr(ifeb_addr_t'(i), 16'h0000);
        end
        wr(IFEB_OFF_IRQ_CLR, 16'hFFFF);
        wr(IFEB_OFF_IRQ_EN, 16'hFFFF);
        rd(IFEB_OFF_IRQ_EN, {13'h0000, IFEB_IRQ_MASK});
        rd(IFEB_OFF_IRQ_STAT, 16'h0000);
        wr(IFEB_OFF_EN3, 16'h4000);
        wr(IFEB_OFF_EN0, 16'h0001);
        idle(1);
        pt = {IFEB_GROUPS * IFEB_DW{3'h1}};
        pt[3][14] = 3'h5;
        pt[0][0] = 3'h7;
        pt[4][3] = 3'h2;
        prio <= pt;
        ext_flags <= ifeb_vec_t'(1);
        ext_en4 <= 16'h0008;
        idle(2);
        #1;
        exp_req = ifeb_vec_t'(1);
        `CHK(core_req, exp_req, "request before events")
        `CHK(level, 3'h7, "level before events")
        `CHK(irq, 1'b0, "interrupt before events")
        // events on every bit, only implemented ones may latch
        i_ifeb_src_model.pulse(16'hFFFF, 16'hFFFF);
        rd(IFEB_OFF_FLAGS3, 16'h4066);
        rd(IFEB_OFF_FLAGS4, 16'h000E);
        rd(IFEB_OFF_IRQ_STAT, 16'h0003);
        idle(2);
        #1;
        exp_req[3][14] = 1'b1;
        exp_req[4][3] = 1'b1;
        `CHK(core_req, exp_req, "requests after events")
        `CHK(irq, 1'b1, "interrupt after events")
        // priority zero removes the top source, next highest wins
        pt[0][0] = IFEB_PRIO_OFF;
        @(posedge sys_clk_in);
        prio <= pt;
        idle(2);
        #1;
        exp_req[0][0] = 1'b0;
        `CHK(core_req, exp_req, "request with priority zero")
        `CHK(level, 3'h5, "level with priority zero")
        wr(IFEB_OFF_EN3, 16'h0000);
        idle(2);
        #1;
        exp_req[3][14] = 1'b0;
        `CHK(core_req, exp_req, "request with enable cleared")
        `CHK(level, 3'h2, "level with enable cleared")
        // masking and clearing the block interrupt
        wr(IFEB_OFF_IRQ_EN, 16'h0000);
        idle(1);
        #1;
        `CHK(irq, 1'b0, "interrupt masked")
        wr(IFEB_OFF_IRQ_EN, 16'h0007);
        idle(1);
        #1;
        `CHK(irq, 1'b1, "interrupt unmasked")
        wr(IFEB_OFF_IRQ_CLR, 16'hFFFF);
        idle(1);
        #1;
        `CHK(irq, 1'b0, "interrupt cleared")
        // an event in the same cycle as a clearing write keeps its flag
        fork
            i_ifeb_src_model.pulse(16'h0040, 16'h0000);
            begin
                wr(IFEB_OFF_FLAGS3, 16'h0000);
                idle(1);
            end
        join
        rd(IFEB_OFF_FLAGS3, 16'h0040);
        wr(IFEB_OFF_FLAGS4, 16'h0000);
        rd(IFEB_OFF_FLAGS4, 16'h0000);
        // a status event in the same cycle as its clear survives
        fork
            i_ifeb_src_model.pulse(16'h0000, 16'h0002);
            begin
                wr(IFEB_OFF_IRQ_CLR, 16'hFFFF);
                idle(1);
            end
        join
        rd(IFEB_OFF_IRQ_STAT, 16'h0002);
        idle(2);
        #1;
        exp_req[4][3] = 1'b0;
        `CHK(core_req, exp_req, "request after service")
        // second reset in mid-run clears everything again
        @(posedge sys_clk_in);
        rst_n_in <= 1'b0;
        idle(2);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 9; i++) rd(ifeb_addr_t'(i), IFEB_RST_WORD);
        idle(2);
        #1;
        `CHK(core_req, ifeb_vec_t'(0), "request after reset")
        test_done();
    end
endmodule
